/* File: src/hsq_defines.svh */
`ifndef HSQ_DEFINES_SVH
`define HSQ_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HSQ_OFS_CTRL      8'h00
`define HSQ_OFS_HI_SPEED  8'h04
`define HSQ_OFS_LO_SPEED  8'h08
`define HSQ_OFS_STATUS    8'h0C
`define HSQ_OFS_HOME_POS  8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HSQ_CTRL_START    0
`define HSQ_CTRL_ABORT    1
`define HSQ_CTRL_MODE_LSB 8
`define HSQ_CTRL_MODE_MSB 10
`define HSQ_ST_BUSY       0
`define HSQ_ST_DONE       1
`define HSQ_ST_ALARM      2
`define HSQ_ST_NEG_LIM    3
`define HSQ_ST_POS_LIM    4
`define HSQ_ST_HOME_SW    5
`define HSQ_ST_STATE_LSB  8
`define HSQ_ST_STATE_MSB  15

// ----------------------------------------------------------------
// reset values and legal mode range
// ----------------------------------------------------------------
`define HSQ_RST_MODE      3'h1
`define HSQ_RST_SPEED     32'h0000_0000
`define HSQ_MODE_FIRST    3'h1
`define HSQ_MODE_LAST     3'h7

`endif

/* File: src/hsq_pkg.sv */
package hsq_pkg;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [7:0] {
        HSQ_IDLE   = 8'h01,
        HSQ_FAST_A = 8'h02,
        HSQ_REV    = 8'h04,
        HSQ_FAST_B = 8'h08,
        HSQ_STOP   = 8'h10,
        HSQ_SEEK   = 8'h20,
        HSQ_INDEX  = 8'h40,
        HSQ_ABORT  = 8'h80
    } hsq_state_t;

    typedef enum logic [1:0] {
        HSQ_W_NEG  = 2'h0,
        HSQ_W_POS  = 2'h1,
        HSQ_W_HOME = 2'h2
    } hsq_watch_t;

    // ----------------------------------------------------------------
    // per-start sequence plan: direction and target level per phase
    // ----------------------------------------------------------------
    typedef struct packed {
        hsq_watch_t watch;
        logic       a_en;
        logic       a_pos;
        logic       a_tgt;
        logic       b_en;
        logic       b_pos;
        logic       b_tgt;
        logic       c_pos;
        logic       c_tgt;
    } hsq_plan_t;

    // command to the motion profile generator
    typedef struct packed {
        logic run;
        logic positive;
        logic high_speed;
        logic decel_stop;
    } hsq_motion_t;

endpackage

/* File: src/hsq_homing_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hsq_defines.svh"

module hsq_homing_seq
    import hsq_pkg::*;
#(
    parameter int SPD_W = 32,
    parameter int POS_W = 32
) (
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              nrst_in,
    // wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [7:0]        wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    // switches and encoder
    input  wire logic              negative_limit_switch_in,
    input  wire logic              positive_limit_switch_in,
    input  wire logic              home_reference_switch_in,
    input  wire logic              encoder_index_in,
    input  wire logic [POS_W-1:0]  position_in,
    // motion profile generator
    input  wire logic              motion_stopped_in,
    output hsq_motion_t            motion_out,
    output logic      [SPD_W-1:0]  speed_out,
    // homing result
    output logic      [POS_W-1:0]  home_pos_out,
    output logic                   home_load_out,
    output logic                   homing_busy_out,
    output logic                   homing_done_out,
    output logic                   homing_alarm_out
);

    // refuse widths that the 32-bit register file cannot carry
    if (SPD_W < 1 || SPD_W > 32 || POS_W < 1 || POS_W > 32) begin : g_bad_width
        $error("hsq_homing_seq: widths must lie in 1..32");
    end

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       pos_lim_prev_r;
    logic       idx_prev_r;
    logic       neg_lim;
    logic       pos_lim;
    logic       home_sw;
    logic       pos_lim_rise;
    logic       idx_rise;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_r        <= 4'h0;
            sync2_r        <= 4'h0;
            pos_lim_prev_r <= 1'b0;
            idx_prev_r     <= 1'b0;
        end else begin
            sync1_r        <= {encoder_index_in, home_reference_switch_in,
                               positive_limit_switch_in, negative_limit_switch_in};
            sync2_r        <= sync1_r;
            pos_lim_prev_r <= sync2_r[1];
            idx_prev_r     <= sync2_r[3];
        end
    end

    assign neg_lim      = sync2_r[0];
    assign pos_lim      = sync2_r[1];
    assign home_sw      = sync2_r[2];
    assign pos_lim_rise = pos_lim & ~pos_lim_prev_r;
    assign idx_rise     = sync2_r[3] & ~idx_prev_r;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic watched(input hsq_watch_t w, input logic n, input logic p,
                                     input logic h);
        unique case (w)
            HSQ_W_NEG: watched = n;
            HSQ_W_POS: watched = p;
            default:   watched = h;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic hsq_plan_t make_plan(input logic [2:0] mode, input logic n,
                                            input logic p, input logic h);
        logic s;
        hsq_plan_t plan_v;
        plan_v = '0;
        plan_v.watch = (mode == 3'h1) ? HSQ_W_NEG : (mode == 3'h2) ? HSQ_W_POS : HSQ_W_HOME;
        s = watched(plan_v.watch, n, p, h);
        plan_v.a_en  = 1'b1;
        plan_v.a_tgt = ~s;
        case (mode)
            3'h1: begin
                plan_v.a_en  = ~s;
                plan_v.a_pos = 1'b0;
                plan_v.a_tgt = 1'b1;
                plan_v.c_pos = 1'b1;
            end
            3'h2: begin
                plan_v.a_en  = ~s;
                plan_v.a_pos = 1'b1;
                plan_v.a_tgt = 1'b1;
            end
            3'h3: begin
                plan_v.a_pos = ~s;
                plan_v.b_en  = s;
                plan_v.b_pos = 1'b1;
                plan_v.b_tgt = 1'b1;
            end
            3'h4: begin
                plan_v.a_pos = ~s;
                plan_v.b_en  = ~s;
                plan_v.c_pos = 1'b1;
                plan_v.c_tgt = 1'b1;
            end
            3'h5: begin
                plan_v.a_pos = s;
                plan_v.b_en  = s;
                plan_v.b_tgt = 1'b1;
                plan_v.c_pos = 1'b1;
            end
            3'h6: begin
                plan_v.a_pos = s;
                plan_v.b_en  = ~s;
                plan_v.b_pos = 1'b1;
                plan_v.c_tgt = 1'b1;
            end
            default: begin
                plan_v.a_pos = ~s;
                plan_v.b_en  = s;
                plan_v.b_pos = 1'b1;
                plan_v.b_tgt = 1'b1;
            end
        endcase
        make_plan = plan_v;
    endfunction

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [2:0]       mode_cfg_r;
    logic [31:0]      hi_cfg_r;
    logic [31:0]      lo_cfg_r;
    logic             start_req_r;
    logic             abort_req_r;
    logic             wb_req;
    logic             wb_wr;
    hsq_state_t       state_r;

    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wb_wr  = wb_req & wb_we_in;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wb_ack_out  <= 1'b0;
            wb_dat_out  <= 32'h0000_0000;
            mode_cfg_r  <= `HSQ_RST_MODE;
            hi_cfg_r    <= `HSQ_RST_SPEED;
            lo_cfg_r    <= `HSQ_RST_SPEED;
            start_req_r <= 1'b0;
            abort_req_r <= 1'b0;
        end else begin
            wb_ack_out  <= wb_req;
            start_req_r <= 1'b0;
            abort_req_r <= 1'b0;
            wb_dat_out  <= 32'h0000_0000;
            if (wb_wr) begin
                unique case (wb_adr_in)
                    `HSQ_OFS_CTRL: begin
                        if (wb_sel_in[0]) begin
                            start_req_r <= wb_dat_in[`HSQ_CTRL_START];
                            abort_req_r <= wb_dat_in[`HSQ_CTRL_ABORT];
                        end
                        if (wb_sel_in[1]) begin
                            mode_cfg_r <= wb_dat_in[`HSQ_CTRL_MODE_MSB:`HSQ_CTRL_MODE_LSB];
                        end
                    end
                    `HSQ_OFS_HI_SPEED: hi_cfg_r <= merge(hi_cfg_r, wb_dat_in, wb_sel_in);
                    `HSQ_OFS_LO_SPEED: lo_cfg_r <= merge(lo_cfg_r, wb_dat_in, wb_sel_in);
                    default: ;
                endcase
            end else if (wb_req) begin
                unique case (wb_adr_in)
                    `HSQ_OFS_CTRL:
                        wb_dat_out[`HSQ_CTRL_MODE_MSB:`HSQ_CTRL_MODE_LSB] <= mode_cfg_r;
                    `HSQ_OFS_HI_SPEED: wb_dat_out <= hi_cfg_r;
                    `HSQ_OFS_LO_SPEED: wb_dat_out <= lo_cfg_r;
                    `HSQ_OFS_STATUS: begin
                        wb_dat_out[`HSQ_ST_BUSY]    <= homing_busy_out;
                        wb_dat_out[`HSQ_ST_DONE]    <= homing_done_out;
                        wb_dat_out[`HSQ_ST_ALARM]   <= homing_alarm_out;
                        wb_dat_out[`HSQ_ST_NEG_LIM] <= neg_lim;
                        wb_dat_out[`HSQ_ST_POS_LIM] <= pos_lim;
                        wb_dat_out[`HSQ_ST_HOME_SW] <= home_sw;
                        wb_dat_out[`HSQ_ST_STATE_MSB:`HSQ_ST_STATE_LSB] <= state_r;
                    end
                    `HSQ_OFS_HOME_POS: wb_dat_out[POS_W-1:0] <= home_pos_out;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // homing sequencer
    // ----------------------------------------------------------------
    hsq_state_t       after_stop_r;
    hsq_plan_t        plan_r;
    logic [2:0]       mode_r;
    logic [SPD_W-1:0] hi_spd_r;
    logic [SPD_W-1:0] lo_spd_r;
    logic             pos_lim_seen_r;
    logic             rev_on_r;
    logic             lvl;
    logic             moving;
    logic             guard_mode;
    hsq_plan_t        plan_nxt;

    assign lvl        = watched(plan_r.watch, neg_lim, pos_lim, home_sw);
    assign moving     = (state_r == HSQ_FAST_A) || (state_r == HSQ_REV) ||
                        (state_r == HSQ_FAST_B) || (state_r == HSQ_SEEK) ||
                        (state_r == HSQ_INDEX);
    assign guard_mode = (mode_r >= 3'h3) && (mode_r <= 3'h6);
    assign plan_nxt   = make_plan(mode_cfg_r, neg_lim, pos_lim, home_sw);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r          <= HSQ_IDLE;
            after_stop_r     <= HSQ_IDLE;
            plan_r           <= '0;
            mode_r           <= `HSQ_RST_MODE;
            hi_spd_r         <= '0;
            lo_spd_r         <= '0;
            pos_lim_seen_r   <= 1'b0;
            rev_on_r         <= 1'b0;
            motion_out       <= '0;
            home_pos_out     <= '0;
            home_load_out    <= 1'b0;
            homing_busy_out  <= 1'b0;
            homing_done_out  <= 1'b0;
            homing_alarm_out <= 1'b0;
        end else begin
            home_load_out <= 1'b0;
            if (state_r == HSQ_IDLE) begin
                if (start_req_r) begin
                    mode_r           <= mode_cfg_r;
                    hi_spd_r         <= hi_cfg_r[SPD_W-1:0];
                    lo_spd_r         <= lo_cfg_r[SPD_W-1:0];
                    plan_r           <= plan_nxt;
                    pos_lim_seen_r   <= 1'b0;
                    rev_on_r         <= 1'b0;
                    homing_done_out  <= 1'b0;
                    homing_alarm_out <= 1'b0;
                    if (mode_cfg_r < `HSQ_MODE_FIRST || mode_cfg_r > `HSQ_MODE_LAST) begin
                        homing_alarm_out <= 1'b1;
                    end else if (plan_nxt.a_en) begin
                        state_r         <= HSQ_FAST_A;
                        homing_busy_out <= 1'b1;
                        motion_out      <= '{run: 1'b1, positive: plan_nxt.a_pos,
                                             high_speed: 1'b1, decel_stop: 1'b0};
                    end else begin
                        state_r         <= HSQ_SEEK;
                        homing_busy_out <= 1'b1;
                        motion_out      <= '{run: 1'b1, positive: plan_nxt.c_pos,
                                             high_speed: 1'b0, decel_stop: 1'b0};
                    end
                end
            end else if (abort_req_r && state_r != HSQ_STOP && state_r != HSQ_ABORT) begin
                state_r               <= HSQ_ABORT;
                motion_out.decel_stop <= 1'b1;
            end else if (moving && guard_mode && (neg_lim || pos_lim)) begin
                state_r               <= HSQ_ABORT;
                homing_alarm_out      <= 1'b1;
                motion_out.decel_stop <= 1'b1;
            end else if (moving && mode_r == 3'h7 && (neg_lim || (pos_lim_rise && pos_lim_seen_r))) begin
                state_r               <= HSQ_ABORT;
                homing_alarm_out      <= 1'b1;
                motion_out.decel_stop <= 1'b1;
            end else if (moving && mode_r == 3'h7 && pos_lim_rise) begin
                pos_lim_seen_r        <= 1'b1;
                rev_on_r              <= 1'b0;
                after_stop_r          <= HSQ_REV;
                state_r               <= HSQ_STOP;
                motion_out.decel_stop <= 1'b1;
            end else begin
                unique case (state_r)
                    HSQ_FAST_A: begin
                        if (lvl == plan_r.a_tgt) begin
                            after_stop_r          <= plan_r.b_en ? HSQ_FAST_B : HSQ_SEEK;
                            state_r               <= HSQ_STOP;
                            motion_out.decel_stop <= 1'b1;
                        end
                    end
                    HSQ_REV: begin
                        if (home_sw) begin
                            rev_on_r <= 1'b1;
                        end
                        if (rev_on_r && !home_sw) begin
                            after_stop_r          <= HSQ_FAST_B;
                            state_r               <= HSQ_STOP;
                            motion_out.decel_stop <= 1'b1;
                        end
                    end
                    HSQ_FAST_B: begin
                        if (lvl == plan_r.b_tgt) begin
                            after_stop_r          <= HSQ_SEEK;
                            state_r               <= HSQ_STOP;
                            motion_out.decel_stop <= 1'b1;
                        end
                    end
                    HSQ_SEEK: begin
                        if (lvl == plan_r.c_tgt) begin
                            state_r <= HSQ_INDEX;
                        end
                    end
                    HSQ_INDEX: begin
                        if (idx_rise) begin
                            home_pos_out          <= position_in;
                            home_load_out         <= 1'b1;
                            homing_done_out       <= 1'b1;
                            after_stop_r          <= HSQ_IDLE;
                            state_r               <= HSQ_STOP;
                            motion_out.decel_stop <= 1'b1;
                        end
                    end
                    HSQ_STOP: begin
                        if (motion_stopped_in) begin
                            state_r <= after_stop_r;
                            unique case (after_stop_r)
                                HSQ_REV:
                                    motion_out <= '{run: 1'b1, positive: 1'b0,
                                                    high_speed: 1'b1, decel_stop: 1'b0};
                                HSQ_FAST_B:
                                    motion_out <= '{run: 1'b1, positive: plan_r.b_pos,
                                                    high_speed: 1'b1, decel_stop: 1'b0};
                                HSQ_SEEK:
                                    motion_out <= '{run: 1'b1, positive: plan_r.c_pos,
                                                    high_speed: 1'b0, decel_stop: 1'b0};
                                default: begin
                                    motion_out      <= '0;
                                    homing_busy_out <= 1'b0;
                                end
                            endcase
                        end
                    end
                    HSQ_ABORT: begin
                        if (motion_stopped_in) begin
                            state_r         <= HSQ_IDLE;
                            motion_out      <= '0;
                            homing_busy_out <= 1'b0;
                        end
                    end
                    default: state_r <= HSQ_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // speed command
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speed_out <= '0;
        end else if (!motion_out.run || motion_out.decel_stop) begin
            speed_out <= '0;
        end else begin
            speed_out <= motion_out.high_speed ? hi_spd_r : lo_spd_r;
        end
    end

endmodule
`default_nettype wire

/* File: tb/hsq_homing_seq_props.sv */
`timescale 1ns/10ps
`default_nettype none
module hsq_homing_seq_props
    import hsq_pkg::*;
#(
    parameter int SPD_W = 32,
    parameter int POS_W = 32
) (
    input wire logic             ref_clk_in,
    input wire logic             nrst_in,
    input wire logic             wb_cyc_in,
    input wire logic             wb_stb_in,
    input wire logic             wb_ack_out,
    input wire hsq_motion_t      motion_out,
    input wire logic [SPD_W-1:0] speed_out,
    input wire logic [POS_W-1:0] home_pos_out,
    input wire logic             home_load_out,
    input wire logic             homing_busy_out,
    input wire logic             homing_done_out,
    input wire logic             homing_alarm_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // axis commanded to halt or already idle
    wire logic halt = motion_out.decel_stop || !motion_out.run;
    AST_ACK_REQ: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered");
    AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack held");
    AST_LOAD_ONE: assert property (home_load_out |=> !home_load_out)
        else $error("home load held");
    AST_LOAD_DONE: assert property (home_load_out |-> ##[0:1] homing_done_out)
        else $error("no done after capture");
    AST_LOAD_HALT: assert property (home_load_out |-> ##[0:2] halt)
        else $error("no stop after capture");
    AST_HOME_HOLD: assert property ($changed(home_pos_out) |-> home_load_out || $past(home_load_out))
        else $error("home moved without capture");
    AST_ALARM_HALT: assert property ($rose(homing_alarm_out) |-> ##[0:2] halt)
        else $error("alarm without stop");
    AST_IDLE_STILL: assert property (homing_done_out && !homing_busy_out |-> !motion_out.run)
        else $error("motion after homing");
    AST_FLAG_EXCL: assert property (!(homing_done_out && homing_alarm_out))
        else $error("done and alarm together");
    AST_SPEED_HOLD: assert property ((motion_out.run && !halt && $stable(motion_out)) [*2]
        |-> $stable(speed_out))
        else $error("speed changed in a phase");
    AST_SPEED_ZERO: assert property (!motion_out.run [*2] |-> speed_out == '0)
        else $error("speed while idle");
    cover property (home_load_out);
    cover property ($rose(homing_alarm_out));
    cover property (motion_out.run && !motion_out.high_speed);
endmodule
bind hsq_homing_seq hsq_homing_seq_props #(.SPD_W(SPD_W), .POS_W(POS_W)) u_hsq_homing_seq_props (
    .ref_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .motion_out, .speed_out,
    .home_pos_out, .home_load_out, .homing_busy_out, .homing_done_out, .homing_alarm_out);
`default_nettype wire

/* File: tb/hsq_axis_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hsq_axis_model
    import hsq_pkg::*;
(
    input  wire hsq_motion_t motion_in,
    input  wire logic        ref_clk_in,
    input  wire logic [31:0] speed_in,
    input  wire logic        load_in,
    input  wire logic [31:0] load_pos_in,
    output logic             negative_limit_switch_out,
    output logic             positive_limit_switch_out,
    output logic             home_reference_switch_out,
    output logic             encoder_index_out,
    output logic [31:0]      position_out,
    output logic             motion_stopped_out
);
    int pos = 0;
    int brake = 0;
    // axis steps by the commanded speed each cycle, rests two cycles into a brake
    always @(posedge ref_clk_in) begin
        if (load_in) begin
            pos <= $signed(load_pos_in);
        end else if (motion_in.run && !motion_in.decel_stop) begin
            pos <= motion_in.positive ? pos + int'(speed_in) : pos - int'(speed_in);
        end
        brake <= (motion_in.run && motion_in.decel_stop) ? brake + 1 : 0;
    end
    assign motion_stopped_out = !motion_in.run || brake >= 2;
    assign negative_limit_switch_out = pos <= -1000;
    assign positive_limit_switch_out = pos >= 1000;
    assign home_reference_switch_out = pos >= 100 && pos <= 300;
    assign encoder_index_out = (((pos % 50) + 50) % 50) inside {[25:28]};
    assign position_out = pos;
endmodule
`default_nettype wire

/* File: tb/test_hsq_homing_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hsq_defines.svh"
module test_hsq_homing_seq
    import hsq_pkg::*;
;
    typedef struct {logic [2:0] mode; int start; logic alarm; int home; int sp;} hsq_case_t;
    logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ld = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, ldp = 32'h0, rdat, pos, speed, hpos;
    logic        ack, nls, pls, home_sw, idx, stp, hload, busy, done, alarm;
    hsq_motion_t mot;
    int          fail_count = 0, total_checks = 0;
    hsq_case_t   cases [19] = '{
        '{3'h1, 0, 1'b0, -975, 4}, '{3'h1, -1005, 1'b0, -975, 1},
        '{3'h2, 0, 1'b0, 975, 4}, '{3'h2, 1005, 1'b0, 975, 1},
        '{3'h3, 0, 1'b0, 75, 4}, '{3'h3, 200, 1'b0, 75, 4},
        '{3'h4, 0, 1'b0, 125, 4}, '{3'h4, 200, 1'b0, 125, 4},
        '{3'h4, 400, 1'b1, 0, 4}, '{3'h5, 0, 1'b1, 0, 4},
        '{3'h5, 400, 1'b0, 325, 4}, '{3'h5, 200, 1'b0, 325, 4},
        '{3'h6, 400, 1'b0, 275, 4}, '{3'h6, 200, 1'b0, 275, 4},
        '{3'h7, 400, 1'b0, 75, 4}, '{3'h7, 0, 1'b0, 75, 4},
        '{3'h7, 200, 1'b0, 75, 4}, '{3'h7, -1005, 1'b1, 0, 0},
        '{3'h0, 0, 1'b1, 0, 0}};
    always #2 clk = ~clk;
    hsq_homing_seq u_hsq_homing_seq (.ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .negative_limit_switch_in(nls), .positive_limit_switch_in(pls), .home_reference_switch_in(home_sw),
        .encoder_index_in(idx), .position_in(pos), .motion_stopped_in(stp), .motion_out(mot), .speed_out(speed),
        .home_pos_out(hpos), .home_load_out(hload), .homing_busy_out(busy), .homing_done_out(done),
        .homing_alarm_out(alarm));
    hsq_axis_model u_hsq_axis_model (.ref_clk_in(clk), .motion_in(mot), .speed_in(speed), .load_in(ld),
        .load_pos_in(ldp), .negative_limit_switch_out(nls), .positive_limit_switch_out(pls),
        .home_reference_switch_out(home_sw), .encoder_index_out(idx), .position_out(pos), .motion_stopped_out(stp));
    task automatic test_done();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            test_done();
        end
        @(posedge clk);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            $display("[FAIL] busy expected 0 seen 1");
            test_done();
        end
    endtask
    task automatic run(input hsq_case_t c);
        int d;
        logic [31:0] q;
        ld <= 1'b1;
        ldp <= c.start;
        @(posedge clk);
        ld <= 1'b0;
        wb(1'b1, `HSQ_OFS_HI_SPEED, 32'h4, q);
        wb(1'b1, `HSQ_OFS_CTRL, {21'h0, c.mode, 8'h01}, q);
        // a new high speed mid-run must not reach the axis
        wb(1'b1, `HSQ_OFS_HI_SPEED, 32'h9, q);
        chk("speed", c.sp, speed);
        wait_idle();
        chk("alarm", c.alarm, alarm);
        chk("done", !c.alarm, done);
        d = int'($signed(hpos)) - c.home;
        if (!c.alarm) begin
            chk("home", c.home, (d <= 4 && d >= -4 && !$isunknown(hpos)) ? c.home : hpos);
        end
    endtask
    initial begin
        logic [31:0] q;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        wb(1'b0, `HSQ_OFS_HI_SPEED, 32'h0, q);
        chk("hi_reset", `HSQ_RST_SPEED, q);
        wb(1'b1, `HSQ_OFS_LO_SPEED, 32'h1, q);
        wb(1'b0, `HSQ_OFS_LO_SPEED, 32'h0, q);
        chk("lo_speed", 32'h1, q);
        wb(1'b0, 8'h14, 32'h0, q);
        chk("unmapped", 32'h0, q);
        foreach (cases[i]) begin
            run(cases[i]);
        end
        // software abort mid-search: stops without alarm or done
        ld <= 1'b1;
        ldp <= 32'h0;
        @(posedge clk);
        ld <= 1'b0;
        wb(1'b1, `HSQ_OFS_CTRL, 32'h0000_0401, q);
        wb(1'b0, `HSQ_OFS_CTRL, 32'h0, q);
        chk("ctrl_mode", 32'h0000_0400, q);
        chk("busy", 32'h1, busy);
        wb(1'b1, `HSQ_OFS_CTRL, 32'h0000_0402, q);
        wait_idle();
        chk("abort_alarm", 32'h0, alarm);
        chk("abort_done", 32'h0, done);
        test_done();
    end
endmodule
`default_nettype wire
